// ### design/crad_adder.sv
`timescale 1ns/1ps
`default_nettype none
module crad_adder (
    input  wire logic [31:0]      opa,
    input  wire logic [31:0]      opb,
    input  wire crad_pkg::crad_op_t op,
    output logic      [31:0]      sum,
    output logic                  group_carry_out
);
    logic [31:0] gen_t;
    logic [31:0] propagate_term;
    logic [32:0] k;
    logic        carry_in_lsb;
    logic        prx_ad, prx_and, prx_nad, prx_nand;
    logic        gx_ad, gx_and, gx_nad, gate_lo;

    // gating terms decoded per operation
    always_comb begin
        {prx_ad, prx_and, prx_nad, prx_nand, gx_ad, gx_and, gx_nad} = 7'h00;
        carry_in_lsb = 1'b0;
        gate_lo = 1'b0;
        unique case (op)
            crad_pkg::OP_ADD:          {prx_and, prx_nad, gx_ad} = 3'h7;
            crad_pkg::OP_ADD_P1:       {prx_and, prx_nad, gx_ad, carry_in_lsb} = 4'hf; // [RL22]
            crad_pkg::OP_A_MINUS_D:    {prx_ad, prx_nand, gx_and, carry_in_lsb} = 4'hf; // [RL21]
            crad_pkg::OP_A_MINUS_D_M1: {prx_ad, prx_nand, gx_and} = 3'h7;
            crad_pkg::OP_D_MINUS_A:    {prx_ad, prx_nand, gx_nad, carry_in_lsb} = 4'hf;
            crad_pkg::OP_D_MINUS_A_M1: {prx_ad, prx_nand, gx_nad} = 3'h7;
            crad_pkg::OP_AND:          prx_ad = 1'b1; // [RL23]
            crad_pkg::OP_NA_AND_D:     prx_nad = 1'b1;
            crad_pkg::OP_A_AND_ND:     prx_and = 1'b1;
            crad_pkg::OP_OR:           {prx_ad, prx_and, prx_nad} = 3'h7;
            crad_pkg::OP_XOR:          {prx_and, prx_nad} = 2'h3;
            crad_pkg::OP_PASS_A:       {prx_ad, prx_and} = 2'h3;
            crad_pkg::OP_PASS_D:       {prx_ad, prx_nad} = 2'h3;
            crad_pkg::OP_NOT_A:        {prx_nad, prx_nand} = 2'h3;
            crad_pkg::OP_NOT_D:        {prx_and, prx_nand} = 2'h3;
            crad_pkg::OP_NEG_A:        {prx_nad, prx_nand, carry_in_lsb} = 3'h7;
            crad_pkg::OP_NEG_D:        {prx_and, prx_nand, carry_in_lsb} = 3'h7;
            crad_pkg::OP_A_P1:         {prx_ad, prx_and, carry_in_lsb} = 3'h7;
            crad_pkg::OP_D_P1:         {prx_ad, prx_nad, carry_in_lsb} = 3'h7;
            crad_pkg::OP_A_M1:         {prx_nad, prx_nand, gx_ad, gx_and} = 4'hf;
            crad_pkg::OP_D_M1:         {prx_and, prx_nand, gx_ad, gx_nad} = 4'hf;
            default:                   gate_lo = 1'b1;
        endcase
    end

    // per-bit generate/propagate, bit 0 is least significant
    always_comb begin
        for (int n = 0; n < 32; n++) begin
            gen_t[n] = (opa[n] & opb[n] & gx_ad) | (opa[n] & ~opb[n] & gx_and) // [RL19]
                     | (~opa[n] & opb[n] & gx_nad);
            propagate_term[n] = (opa[n] & opb[n] & prx_ad) | (opa[n] & ~opb[n] & prx_and)
                              | (~opa[n] & opb[n] & prx_nad) | (~opa[n] & ~opb[n] & prx_nand);
        end
    end

    // four-bit lookahead groups, group carry feeds the next group
    always_comb begin
        logic [3:0] g4;
        logic [3:0] p4;
        g4 = 4'h0;
        p4 = 4'h0;
        k[0] = carry_in_lsb;
        for (int grp = 0; grp < 8; grp++) begin
            g4 = gen_t[grp*4 +: 4];
            p4 = propagate_term[grp*4 +: 4];
            k[grp*4+1] = g4[0] | (p4[0] & k[grp*4]); // [RL20]
            k[grp*4+2] = g4[1] | (p4[1] & g4[0]) | (p4[1] & p4[0] & k[grp*4]);
            k[grp*4+3] = g4[2] | (p4[2] & g4[1]) | (p4[2] & p4[1] & g4[0])
                       | (p4[2] & p4[1] & p4[0] & k[grp*4]);
            k[grp*4+4] = g4[3] | (p4[3] & g4[2]) | (p4[3] & p4[2] & g4[1])
                       | (p4[3] & p4[2] & p4[1] & g4[0]) | (&p4 & k[grp*4]);
        end
    end

    assign sum = gate_lo ? 32'h0000_0000 : (propagate_term ^ k[31:0]); // [RL18] [RL19]
    assign group_carry_out = k[4];
endmodule // crad_adder
`default_nettype wire

// ### design/crad_datapath.sv
// Overview of operation
// (RL1) hold register keeps program address, stores via sum
// (RL2) hold register carries multiply/divide values, shifts
// (RL3) hold register keeps direct address or status
// (RL4) program address bits 15-31 word, 32-33 control
// (RL5) program address increments and decrements by one
// (RL6) panel address loads program address; indicators show it
// (RL7) pointer register increments and decrements by one
// (RL8) second operand supplies index register address
// (RL9) direct data loads from lines or sum
// (RL10) direct address part loads from hold register
// (RL11) direct data drives sum or external lines
// (RL12) macro counter decrements by exactly one
// (RL13) macro counter loads from P, CC, sum
// (RL14) condition code forms status bits 0-3
// (RL15) internal-mode direct captures panel sense switches
// (RL16) trap during status op captures trap accumulator
// (RL17) condition code loads sum 0-3 or 24-27
// (RL18) adder uses only operand registers, drives sum
// (RL19) generate AND, propagate XOR, sum XOR carry
// (RL20) lookahead carry in four-bit groups
// (RL21) subtract: generate A and not D, XNOR propagate
// (RL22) carry-in forced only for plus-one and subtractions
// (RL23) logic ops form propagate only
// (RL24) registers change only on their load term
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`include "crad_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module crad_datapath (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [18:0] operator_panel_addr,
    input  wire logic [3:0]  panel_sense_switch,
    input  wire logic [3:0]  trap_accumulator,
    input  wire logic [31:0] direct_line_in,
    output logic [31:0]      direct_line_out,
    output logic             direct_line_oe_n,
    output logic [15:0]      direct_addr_out,
    output logic [18:0]      panel_addr_indicator
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        crad_pkg::crad_op_t op;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] hold;
        logic [18:0] paddr;
        logic [3:0]  rptr;
        logic [31:0] dx_data;
        logic [15:0] dx_addr;
        logic        dx_drive;
        logic        dx_read;
        logic [7:0]  macro_counter;
        logic [3:0]  cc;
        logic [31:0] din_s1;
        logic [31:0] din_s2;
        logic [3:0]  sw_s1;
        logic [3:0]  sw_s2;
        logic [3:0]  tr_s1;
        logic [3:0]  tr_s2;
        logic [18:0] pan_s1;
        logic [18:0] pan_s2;
    } crad_state_t;

    crad_state_t st_q;
    crad_state_t st_d;
    logic [31:0] adder_sum;
    logic [31:0] sum_bus;
    logic        group_carry_out;
    logic        wr_fire;
    logic        rd_fire;
    crad_pkg::crad_cmd_t cmd;

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // adder sees only the two operand registers
    crad_adder u_adder (
        .opa             (st_q.opa),
        .opb             (st_q.opb),
        .op              (st_q.op),
        .sum             (adder_sum),
        .group_carry_out (group_carry_out)
    ); // [RL18]

    // direct data replaces adder output on read direct
    assign sum_bus = st_q.dx_read ? st_q.dx_data : adder_sum; // [RL11]

    assign wr_fire = st_q.aw_got && st_q.w_got && !st_q.bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign cmd = (wr_fire && st_q.awaddr == `CRAD_OFF_CMD)
               ? crad_pkg::crad_cmd_t'(st_q.wdata[`CRAD_CMD_SEL_MSB:`CRAD_CMD_SEL_LSB])
               : crad_pkg::CMD_NONE;

    assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
    assign s_axi_wready  = !st_q.w_got && !st_q.bvalid;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;

    assign direct_line_out      = st_q.dx_data;
    assign direct_line_oe_n     = !st_q.dx_drive; // [RL11]
    assign direct_addr_out      = st_q.dx_addr;
    assign panel_addr_indicator = st_q.paddr; // [RL6]

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        st_d.din_s1 = direct_line_in;
        st_d.din_s2 = st_q.din_s1;
        st_d.sw_s1  = panel_sense_switch;
        st_d.sw_s2  = st_q.sw_s1;
        st_d.tr_s1  = trap_accumulator;
        st_d.tr_s2  = st_q.tr_s1;
        st_d.pan_s1 = operator_panel_addr;
        st_d.pan_s2 = st_q.pan_s1;

        // bus write side
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = `CRAD_OKAY;
            unique case (st_q.awaddr)
                `CRAD_OFF_CTRL: st_d.op = crad_pkg::crad_op_t'(
                    st_q.wdata[`CRAD_CTRL_OP_MSB:`CRAD_CTRL_OP_LSB]);
                `CRAD_OFF_OPA:  st_d.opa = merge_strb(st_q.opa, st_q.wdata, st_q.wstrb);
                `CRAD_OFF_OPB:  st_d.opb = merge_strb(st_q.opb, st_q.wdata, st_q.wstrb);
                `CRAD_OFF_CMD:  st_d.bresp = `CRAD_OKAY;
                default:        st_d.bresp = `CRAD_SLVERR;
            endcase
        end

        // sequencer commands, each register moves only on its own term
        unique case (cmd) // [RL24]
            crad_pkg::CMD_HOLD_FROM_P:   st_d.hold = {13'h0000, st_q.paddr}; // [RL1]
            crad_pkg::CMD_HOLD_FROM_SUM: st_d.hold = sum_bus; // [RL1] [RL3]
            crad_pkg::CMD_HOLD_SHL:      st_d.hold = {st_q.hold[30:0], adder_sum[31]}; // [RL2]
            crad_pkg::CMD_HOLD_SHR:      st_d.hold = {adder_sum[0], st_q.hold[31:1]}; // [RL2]
            crad_pkg::CMD_P_INC:         st_d.paddr = st_q.paddr + 19'h0_0001; // [RL5]
            crad_pkg::CMD_P_DEC:         st_d.paddr = st_q.paddr - 19'h0_0001; // [RL5]
            crad_pkg::CMD_P_FROM_PANEL:  st_d.paddr = st_q.pan_s2; // [RL6]
            crad_pkg::CMD_P_FROM_SUM:    st_d.paddr = {sum_bus[16:0], 2'b00}; // [RL4]
            crad_pkg::CMD_RP_INC:        st_d.rptr = st_q.rptr + 4'h1; // [RL7]
            crad_pkg::CMD_RP_DEC:        st_d.rptr = st_q.rptr - 4'h1; // [RL7]
            crad_pkg::CMD_RP_FROM_IDX:
                st_d.rptr = st_q.opb[`CRAD_IDX_LSB +: 4]; // [RL8]
            crad_pkg::CMD_DX_READ: begin
                st_d.dx_data  = st_q.din_s2; // [RL9]
                st_d.dx_drive = 1'b0;
                st_d.dx_read  = 1'b1; // [RL11]
            end
            crad_pkg::CMD_DX_WRITE: begin
                st_d.dx_data  = adder_sum; // [RL9]
                st_d.dx_drive = 1'b1; // [RL11]
                st_d.dx_read  = 1'b0;
            end
            crad_pkg::CMD_DX_END: begin
                st_d.dx_drive = 1'b0;
                st_d.dx_read  = 1'b0;
            end
            crad_pkg::CMD_DX_ADDR:       st_d.dx_addr = st_q.hold[15:0]; // [RL10]
            crad_pkg::CMD_MC_DEC:
                st_d.macro_counter = st_q.macro_counter - 8'h01; // [RL12]
            crad_pkg::CMD_MC_FROM_P:     st_d.macro_counter = st_q.paddr[7:0]; // [RL13]
            crad_pkg::CMD_MC_FROM_CC:    st_d.macro_counter = {4'h0, st_q.cc}; // [RL13]
            crad_pkg::CMD_MC_FROM_SUM:   st_d.macro_counter = sum_bus[7:0]; // [RL13]
            crad_pkg::CMD_A_FROM_MC:     st_d.opa = {24'h00_0000, st_q.macro_counter}; // [RL13]
            crad_pkg::CMD_CC_SENSE:      st_d.cc = st_q.sw_s2; // [RL15]
            crad_pkg::CMD_CC_TRAP:       st_d.cc = st_q.tr_s2; // [RL16]
            crad_pkg::CMD_CC_SUM_LO:     st_d.cc = sum_bus[31:28]; // [RL17]
            crad_pkg::CMD_CC_SUM_HI:     st_d.cc = sum_bus[7:4]; // [RL17]
            crad_pkg::CMD_A_FROM_SUM:    st_d.opa = sum_bus;
            crad_pkg::CMD_D_FROM_SUM:    st_d.opb = sum_bus;
            default:                     st_d.op = st_d.op;
        endcase

        // bus read side
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (rd_fire) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = `CRAD_OKAY;
            unique case (s_axi_araddr)
                `CRAD_OFF_CTRL:   st_d.rdata = {27'h000_0000, st_q.op};
                `CRAD_OFF_CMD:    st_d.rdata = `CRAD_RST_32;
                `CRAD_OFF_OPA:    st_d.rdata = st_q.opa;
                `CRAD_OFF_OPB:    st_d.rdata = st_q.opb;
                `CRAD_OFF_SUM:    st_d.rdata = sum_bus;
                `CRAD_OFF_HOLD:   st_d.rdata = st_q.hold;
                `CRAD_OFF_PADDR:  st_d.rdata = {13'h0000, st_q.paddr};
                `CRAD_OFF_DXDATA: st_d.rdata = st_q.dx_data;
                `CRAD_OFF_DXADDR: st_d.rdata = {16'h0000, st_q.dx_addr};
                `CRAD_OFF_STATUS: st_d.rdata = {8'h00, st_q.opb[`CRAD_IDX_LSB +: 4], // [RL8]
                    3'h0, st_q.dx_drive, st_q.macro_counter, st_q.rptr, st_q.cc}; // [RL14]
                `CRAD_OFF_DIN:    st_d.rdata = st_q.din_s2;
                default: begin
                    st_d.rdata = `CRAD_RST_32;
                    st_d.rresp = `CRAD_SLVERR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q          <= '0;
            st_q.op       <= crad_pkg::OP_ADD;
            st_q.paddr    <= `CRAD_RST_P;
            st_q.macro_counter <= `CRAD_RST_MC;
            st_q.cc       <= `CRAD_RST_CC;
            st_q.dx_addr  <= `CRAD_RST_DXA;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_mc_dec;
        cmd == crad_pkg::CMD_MC_DEC;
    endsequence

    sequence s_dx_read;
        cmd == crad_pkg::CMD_DX_READ;
    endsequence

    // stepping registers and panel address load
    a_mc_decrement: assert property ( // [RL12]
        s_mc_dec |=> st_q.macro_counter == $past(st_q.macro_counter) - 8'h01)
        else $error("macro counter did not drop by one");

    a_p_increment: assert property ( // [RL5]
        cmd == crad_pkg::CMD_P_INC |=> st_q.paddr == $past(st_q.paddr) + 19'h0_0001)
        else $error("program address did not step up");

    a_p_decrement: assert property ( // [RL5]
        cmd == crad_pkg::CMD_P_DEC |=> st_q.paddr == $past(st_q.paddr) - 19'h0_0001)
        else $error("program address did not step down");

    a_panel_show: assert property ( // [RL6]
        cmd == crad_pkg::CMD_P_FROM_PANEL |=> panel_addr_indicator == $past(st_q.pan_s2))
        else $error("panel address not shown");

    a_rp_decrement: assert property ( // [RL7]
        cmd == crad_pkg::CMD_RP_DEC |=> st_q.rptr == $past(st_q.rptr) - 4'h1)
        else $error("pointer did not step down");

    // direct transfer path
    a_dx_addr_load: assert property ( // [RL10]
        cmd == crad_pkg::CMD_DX_ADDR |=> direct_addr_out == $past(st_q.hold[15:0]))
        else $error("direct address not from hold");

    a_dx_read_load: assert property ( // [RL9]
        s_dx_read |=> st_q.dx_data == $past(st_q.din_s2) && sum_bus == st_q.dx_data)
        else $error("read direct data not loaded");

    a_dx_write_drive: assert property ( // [RL11]
        cmd == crad_pkg::CMD_DX_WRITE |=> !direct_line_oe_n && sum_bus == adder_sum)
        else $error("write direct not driving lines");

    // condition code loads, then adder results
    a_cc_trap_load: assert property ( // [RL16]
        cmd == crad_pkg::CMD_CC_TRAP |=> st_q.cc == $past(st_q.tr_s2))
        else $error("trap bits not captured");

    a_cc_sense_load: assert property ( // [RL15]
        cmd == crad_pkg::CMD_CC_SENSE |=> st_q.cc == $past(st_q.sw_s2))
        else $error("sense switches not captured");

    a_cc_sum_high: assert property ( // [RL17]
        cmd == crad_pkg::CMD_CC_SUM_HI |=> st_q.cc == $past(sum_bus[7:4]))
        else $error("condition code not from sum 24-27");

    a_cc_hold_val: assert property ( // [RL24]
        !(wr_fire && st_q.awaddr == `CRAD_OFF_CMD) |=> $stable(st_q.cc))
        else $error("condition code changed without load");

    a_add_result: assert property ( // [RL19]
        st_q.op == crad_pkg::OP_ADD && !st_q.dx_read |-> sum_bus == st_q.opa + st_q.opb)
        else $error("adder sum wrong");

    a_sub_result: assert property ( // [RL21]
        st_q.op == crad_pkg::OP_A_MINUS_D |-> adder_sum == st_q.opa - st_q.opb)
        else $error("subtraction wrong");
endmodule // crad_datapath
`default_nettype wire

// ### design/crad_defs.svh
`ifndef CRAD_DEFS_SVH
`define CRAD_DEFS_SVH
// register offsets (byte addresses)
`define CRAD_OFF_CTRL    8'h00
`define CRAD_OFF_CMD     8'h04
`define CRAD_OFF_OPA     8'h08
`define CRAD_OFF_OPB     8'h0c
`define CRAD_OFF_SUM     8'h10
`define CRAD_OFF_HOLD    8'h14
`define CRAD_OFF_PADDR   8'h18
`define CRAD_OFF_DXDATA  8'h1c
`define CRAD_OFF_DXADDR  8'h20
`define CRAD_OFF_STATUS  8'h24
`define CRAD_OFF_DIN     8'h28
// field positions
`define CRAD_CTRL_OP_LSB    0
`define CRAD_CTRL_OP_MSB    4
`define CRAD_CMD_SEL_LSB    0
`define CRAD_CMD_SEL_MSB    4
`define CRAD_ST_CC_LSB      0
`define CRAD_ST_CC_MSB      3
`define CRAD_ST_RP_LSB      4
`define CRAD_ST_RP_MSB      7
`define CRAD_ST_MC_LSB      8
`define CRAD_ST_MC_MSB      15
`define CRAD_ST_DOUT_BIT    16
`define CRAD_ST_IDX_LSB     20
`define CRAD_ST_IDX_MSB     23
`define CRAD_IDX_LSB        12
// reset values and bus response codes
`define CRAD_RST_32      32'h0000_0000
`define CRAD_RST_P       19'h0_0000
`define CRAD_RST_MC      8'h00
`define CRAD_RST_CC      4'h0
`define CRAD_RST_DXA     16'h0000
`define CRAD_SLVERR      2'b10
`define CRAD_OKAY        2'b00
`endif

// ### design/crad_pkg.sv
package crad_pkg;
    // adder operations
    typedef enum logic [4:0] {
        OP_ADD, OP_ADD_P1, OP_A_MINUS_D, OP_A_MINUS_D_M1, OP_D_MINUS_A,
        OP_D_MINUS_A_M1, OP_AND, OP_NA_AND_D, OP_A_AND_ND, OP_OR, OP_XOR,
        OP_PASS_A, OP_PASS_D, OP_NOT_A, OP_NOT_D, OP_NEG_A, OP_NEG_D,
        OP_A_P1, OP_D_P1, OP_A_M1, OP_D_M1
    } crad_op_t;
    // one-shot load/gating commands from the sequencer
    typedef enum logic [4:0] {
        CMD_NONE, CMD_HOLD_FROM_P, CMD_HOLD_FROM_SUM, CMD_HOLD_SHL, CMD_HOLD_SHR,
        CMD_P_INC, CMD_P_DEC, CMD_P_FROM_PANEL, CMD_P_FROM_SUM,
        CMD_RP_INC, CMD_RP_DEC, CMD_RP_FROM_IDX,
        CMD_DX_READ, CMD_DX_WRITE, CMD_DX_ADDR,
        CMD_MC_DEC, CMD_MC_FROM_P, CMD_MC_FROM_CC, CMD_MC_FROM_SUM, CMD_A_FROM_MC,
        CMD_CC_SENSE, CMD_CC_TRAP, CMD_CC_SUM_LO, CMD_CC_SUM_HI,
        CMD_A_FROM_SUM, CMD_D_FROM_SUM, CMD_DX_END
    } crad_cmd_t;
endpackage

// ### sim/cpu_register_adder_datapath_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_register_adder_datapath_tb_top;
    typedef struct {crad_pkg::crad_cmd_t c; logic [7:0] a; logic [31:0] m, e;} crad_row_t;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, direct_line_oe_n;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb, panel_sense_switch, trap_accumulator;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_wdata, s_axi_rdata, direct_line_in, direct_line_out, seen, v;
    logic [18:0] operator_panel_addr, panel_addr_indicator;
    logic [15:0] direct_addr_out;
    logic [31:0] sums [21];
    crad_row_t   rows [22];
    int          failures, checked;
    crad_datapath dut (.*);
    crad_dio_dev dev (.aclk(aclk), .line_oe_n(direct_line_oe_n), .line_out(direct_line_out),
                      .dev_data(32'hc3a50f96), .line_in(direct_line_in), .seen_q(seen));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one bus transfer
    task automatic xfer(input logic wrt, input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic ha, hw, hr, hd;
        n = 0;
        {s_axi_awaddr, s_axi_araddr} <= {a, a};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {wrt, wrt, ~wrt};
        do begin
            @(negedge aclk);
            ha = s_axi_awvalid & (s_axi_awready === 1'b1);
            hw = s_axi_wvalid & (s_axi_wready === 1'b1);
            hr = s_axi_arvalid & (s_axi_arready === 1'b1);
            hd = wrt ? (s_axi_bvalid === 1'b1) : (s_axi_rvalid === 1'b1);
            r = wrt ? s_axi_bresp : s_axi_rresp;
            v = s_axi_rdata;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hr) s_axi_arvalid <= 1'b0;
            n++;
            if (n > 40) begin
                chk("bus answer", 32'h1, 32'h0);
                summarize();
            end
        end while (!hd);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(n, e, v);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        {panel_sense_switch, trap_accumulator, operator_panel_addr} = 27'h0;
        {failures, checked} = 64'h0;
        sums = '{32'h80000001, 32'h80000002, 32'h7ffffffb, 32'h7ffffffa, 32'h80000005,
                 32'h80000004, 32'h00000002, 32'h00000001, 32'h7ffffffc, 32'h7fffffff,
                 32'h7ffffffd, 32'h7ffffffe, 32'h00000003, 32'h80000001, 32'hfffffffc,
                 32'h80000002, 32'hfffffffd, 32'h7fffffff, 32'h00000004, 32'h7ffffffd,
                 32'h00000002};
        rows = '{'{crad_pkg::CMD_P_FROM_PANEL, 8'h18, 32'h7ffff, 32'h7fffe},
                 '{crad_pkg::CMD_P_INC, 8'h18, 32'h7ffff, 32'h7ffff},
                 '{crad_pkg::CMD_P_DEC, 8'h18, 32'h7ffff, 32'h7fffe},
                 '{crad_pkg::CMD_MC_FROM_P, 8'h24, 32'hff00, 32'hfe00},
                 '{crad_pkg::CMD_MC_DEC, 8'h24, 32'hff00, 32'hfd00},
                 '{crad_pkg::CMD_RP_FROM_IDX, 8'h24, 32'hf000f0, 32'hf000f0},
                 '{crad_pkg::CMD_RP_INC, 8'h24, 32'hf0, 32'h0},
                 '{crad_pkg::CMD_RP_DEC, 8'h24, 32'hf0, 32'hf0},
                 '{crad_pkg::CMD_CC_SENSE, 8'h24, 32'hf, 32'ha},
                 '{crad_pkg::CMD_CC_TRAP, 8'h24, 32'hf, 32'h5},
                 '{crad_pkg::CMD_CC_SUM_LO, 8'h24, 32'hf, 32'h9},
                 '{crad_pkg::CMD_CC_SUM_HI, 8'h24, 32'hf, 32'h6},
                 '{crad_pkg::CMD_HOLD_FROM_SUM, 8'h14, 32'hffffffff, 32'h90000060},
                 '{crad_pkg::CMD_DX_ADDR, 8'h20, 32'hffff, 32'h60},
                 '{crad_pkg::CMD_MC_FROM_CC, 8'h24, 32'hff00, 32'h600},
                 '{crad_pkg::CMD_MC_FROM_SUM, 8'h24, 32'hff00, 32'h6000},
                 '{crad_pkg::CMD_HOLD_FROM_P, 8'h14, 32'hffffffff, 32'h7fffe},
                 '{crad_pkg::CMD_HOLD_SHL, 8'h14, 32'hffffffff, 32'hffffd},
                 '{crad_pkg::CMD_HOLD_SHR, 8'h14, 32'hffffffff, 32'h7fffe},
                 '{crad_pkg::CMD_D_FROM_SUM, 8'h0c, 32'hffffffff, 32'h90000060},
                 '{crad_pkg::CMD_A_FROM_MC, 8'h08, 32'hffffffff, 32'h60},
                 '{crad_pkg::CMD_P_FROM_SUM, 8'h18, 32'h7ffff, 32'h180}};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rc("status", 8'h24, 32'h0);
        rc("paddr", 8'h18, 32'h0);
        $display("test reset done");
        xfer(1'b1, 8'h04, 32'(crad_pkg::CMD_DX_WRITE));
        xfer(1'b1, 8'h08, 32'h7ffffffe);
        xfer(1'b1, 8'h0c, 32'h00000003);
        for (int i = 0; i < 21; i++) begin
            xfer(1'b1, 8'h00, 32'(i));
            rc("sum", 8'h10, sums[i]);
        end
        xfer(1'b1, 8'h00, 32'h1f);
        rc("sum bad op", 8'h10, 32'h0);
        $display("test adder done");
        panel_sense_switch <= 4'ha;
        trap_accumulator <= 4'h5;
        operator_panel_addr <= 19'h7fffe;
        xfer(1'b1, 8'h00, 32'(crad_pkg::OP_PASS_A));
        xfer(1'b1, 8'h08, 32'h90000060);
        xfer(1'b1, 8'h0c, 32'h0000f000);
        foreach (rows[i]) begin
            xfer(1'b1, 8'h04, 32'(rows[i].c));
            xfer(1'b0, rows[i].a, 32'h0);
            chk("row", rows[i].e, v & rows[i].m);
        end
        chk("addr pins", 32'h60, {16'h0, direct_addr_out});
        chk("indicator", 32'h180, {13'h0, panel_addr_indicator});
        xfer(1'b0, 8'h2c, 32'h0);
        chk("rresp", 32'h2, {30'h0, r});
        xfer(1'b1, 8'h30, 32'h1);
        chk("bresp", 32'h2, {30'h0, r});
        $display("test registers done");
        xfer(1'b1, 8'h08, 32'h12345678);
        xfer(1'b1, 8'h04, 32'(crad_pkg::CMD_DX_WRITE));
        rc("dx data", 8'h1c, 32'h12345678);
        chk("lines", 32'h12345678, seen);
        chk("oe_n", 32'h0, {31'h0, direct_line_oe_n});
        xfer(1'b1, 8'h04, 32'(crad_pkg::CMD_DX_END));
        rc("status drive", 8'h24, 32'h000060f6);
        rc("lines in", 8'h28, 32'hc3a50f96);
        xfer(1'b1, 8'h04, 32'(crad_pkg::CMD_DX_READ));
        rc("dx read", 8'h1c, 32'hc3a50f96);
        rc("sum from dx", 8'h10, 32'hc3a50f96);
        $display("test direct done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc("paddr reset", 8'h18, 32'h0);
        chk("oe_n reset", 32'h1, {31'h0, direct_line_oe_n});
        xfer(1'b1, 8'h08, 32'h5);
        rc("sum after reset", 8'h10, 32'h5);
        $display("test reset again done");
        summarize();
    end
endmodule // cpu_register_adder_datapath_tb_top
`default_nettype wire

// ### sim/crad_dio_dev.sv
`timescale 1ns/1ps
`default_nettype none
module crad_dio_dev (
    input  wire logic        aclk,
    input  wire logic        line_oe_n,
    input  wire logic [31:0] line_out,
    input  wire logic [31:0] dev_data,
    output logic      [31:0] line_in,
    output logic      [31:0] seen_q
);
    // device drives the lines only while the processor has let them go
    assign line_in = line_oe_n ? dev_data : line_out;
    always_ff @(posedge aclk) if (!line_oe_n) seen_q <= line_out;
endmodule // crad_dio_dev
`default_nettype wire
